//--- rtl/port_ingress_consts.svh
// Purpose: offsets, field positions, reset values of the ingress regs
// Assumes: register index times four gives the byte address
// Notes: definitions only
`ifndef PORT_INGRESS_CONSTS_SVH
`define PORT_INGRESS_CONSTS_SVH

// register indices
`define IDX_CLASSIFY_EN 12'h801
`define IDX_FRAME_CTRL 12'h802
`define IDX_AUTH_CTRL 12'h803
`define IDX_QUEUE_PTR 12'h804
`define IDX_PRIO_MAP 12'h808
`define IDX_DEF_TAG_PRIO 12'h840

// bus widths
`define ADDR_W 14
`define DATA_W 32

// classification enable fields
`define CLS_DSCP_BIT 1
`define CLS_DOT1P_BIT 2
`define CLS_VLAN_BIT 3

// frame control fields
`define FC_CEIL_BIT 7
`define FC_DROP_UNTAG_BIT 4
`define FC_DROP_TAG_BIT 3
`define FC_DEF_PRIO_MSB 2

// authentication control fields
`define AC_ACL_EN_BIT 2
`define AUTH_PASS 2'h0
`define AUTH_BLOCK 2'h1
`define AUTH_TRAP 2'h2

// pointer fields
`define PTR_PORT_LSB 16
`define PTR_PORT_MSB 18
`define PTR_QUEUE_MSB 1

// reset values
`define RST_CLASSIFY_EN 3'h0
`define RST_FRAME_CTRL 8'h00
`define RST_AUTH_MODE 2'h0
`define RST_PORT_IDX 3'h0
`define RST_QUEUE_PTR 2'h0
`define RST_PRIO_MAP 32'h33221100
`define RST_DEF_TAG_PRIO 3'h0

`endif

//--- rtl/port_ingress_pkg.sv
// Purpose: shared types of the ingress control block
// Assumes: constants live in port_ingress_consts.svh
// Notes: none
package port_ingress_pkg;
    typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;
    typedef logic [2:0] prio_t;
    typedef logic [1:0] queue_t;
endpackage : port_ingress_pkg

//--- rtl/queue_map_lookup.sv
// Purpose: priority to queue lookup in the remap table
// Assumes: one nibble per priority, priority 7 on top
// Notes: upper two bits of each nibble are ignored
`timescale 1ns/1ps
module queue_map_lookup (
    // table
    input wire logic [31:0] mapTable,
    // lookup
    input wire port_ingress_pkg::prio_t prio,
    output port_ingress_pkg::queue_t queue
);
    import port_ingress_pkg::*;

    wire [4:0] nibbleBase = {prio, 2'b00};

    assign queue = mapTable[nibbleBase +: 2];
endmodule : queue_map_lookup

//--- rtl/port_ingress_classify_ctrl.sv
// Purpose: per-port ingress classify and filter control registers
// Assumes: Avalon-MM slave with waitrequest, byte addresses
// Notes: one frame decision per cycle, one cycle latency
//
// Function
// - ceiling set and tag priority above default tag: replace with default
// - discard-untagged set drops every frame without an 802.1Q tag
// - discard-tagged set drops every frame carrying an 802.1Q tag
// - no classifier enabled or hit: use 3-bit port default priority
// - read-only ACL enable flag at bit 2 of authentication control
// - mode 00 pass; with ACL, misses forward, hits take actions
// - mode 01 block; with ACL, misses blocked, hits take actions
// - mode 10 trap to host; with ACL, misses blocked, hits act
// - pointer bits 18:16 hold the 3-bit port index
// - pointer bits 1:0 hold the 2-bit queue pointer
// - priority p maps to queue via low two bits of nibble p
// - reset map: 0,1->q0; 2,3->q1; 4,5->q2; 6,7->q3
// - per-port enables for DSCP, 802.1p and VLAN classification
`timescale 1ns/1ps
`include "port_ingress_consts.svh"
module port_ingress_classify_ctrl (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // avalon-mm slave
    input wire logic [`ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [`DATA_W-1:0] writedata,
    output logic [`DATA_W-1:0] readdata,
    output logic waitrequest,
    // acl block status
    input wire logic aclEnable,
    // ingress frame descriptor
    input wire logic frmValid,
    input wire logic frmTagged,
    input wire port_ingress_pkg::prio_t frmUserPrio,
    input wire logic dscpHit,
    input wire port_ingress_pkg::prio_t dscpPrio,
    input wire logic vlanHit,
    input wire port_ingress_pkg::prio_t vlanPrio,
    input wire logic aclHit,
    // frame decision
    output logic decValid,
    output logic decDrop,
    output logic decToHost,
    output logic decAclApply,
    output port_ingress_pkg::prio_t decUserPrio,
    output port_ingress_pkg::prio_t decPrio,
    output port_ingress_pkg::queue_t decQueue,
    // indirect pointer
    output port_ingress_pkg::prio_t portIndex,
    output port_ingress_pkg::queue_t queuePtr
);
    import port_ingress_pkg::*;

    // register state
    bus_state_t busState_r;
    logic [`DATA_W-1:0] readData_r;
    logic [2:0] classifyEn_r;
    logic ceilEn_r;
    logic dropUntag_r;
    logic dropTag_r;
    prio_t defPrio_r;
    logic [1:0] authMode_r;
    prio_t portIdx_r;
    queue_t queuePtr_r;
    logic [31:0] prioMap_r;
    prio_t defTagPrio_r;

    // decision state
    logic decValid_r;
    logic decDrop_r;
    logic decToHost_r;
    logic decAclApply_r;
    prio_t decUserPrio_r;
    prio_t decPrio_r;
    queue_t decQueue_r;

    // frame control reset image
    localparam logic [7:0] frameCtrlReset = `RST_FRAME_CTRL;

    // address decode
    wire [11:0] wordIdx = address[`ADDR_W-1:2];
    wire hitCls = (wordIdx == `IDX_CLASSIFY_EN);
    wire hitFc = (wordIdx == `IDX_FRAME_CTRL);
    wire hitAc = (wordIdx == `IDX_AUTH_CTRL);
    wire hitPtr = (wordIdx == `IDX_QUEUE_PTR);
    wire hitMap = (wordIdx == `IDX_PRIO_MAP);
    wire hitDef = (wordIdx == `IDX_DEF_TAG_PRIO);

    // access completes on the second cycle of a request
    wire busReq = read | write;
    wire accDone = busReq & (busState_r == BUS_ACK);
    wire wrDone = write & accDone;
    wire rdTake = read & (busState_r == BUS_IDLE);
    wire be0 = byteenable[0];
    wire be2 = byteenable[2];

    assign waitrequest = busReq & (busState_r == BUS_IDLE);

    // write enables per field
    wire wrCls = wrDone & hitCls & be0;
    wire wrFc = wrDone & hitFc & be0;
    wire wrAc = wrDone & hitAc & be0;
    wire wrPtrPort = wrDone & hitPtr & be2;
    wire wrPtrQueue = wrDone & hitPtr & be0;
    wire wrDef = wrDone & hitDef & be0;
    wire [3:0] wrMapLane = {4{wrDone & hitMap}} & byteenable;

    // read values, reserved bits zero
    wire [7:0] clsVal = {4'h0, classifyEn_r, 1'b0};
    wire [7:0] fcVal = {ceilEn_r, 2'b00, dropUntag_r, dropTag_r,
        defPrio_r};
    wire [7:0] acVal = {5'h00, aclEnable, authMode_r};
    wire [31:0] ptrVal = {13'h0000, portIdx_r, 14'h0000,
        queuePtr_r};
    wire [31:0] mapVal = prioMap_r & 32'h33333333;
    wire [31:0] rdMux =
        hitCls ? {24'h000000, clsVal} :
        hitFc ? {24'h000000, fcVal} :
        hitAc ? {24'h000000, acVal} :
        hitPtr ? ptrVal :
        hitMap ? mapVal :
        hitDef ? {29'h00000000, defTagPrio_r} :
        32'h00000000;

    // bus handshake
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            busState_r <= BUS_IDLE;
        end else if (busReq && busState_r == BUS_IDLE) begin
            busState_r <= BUS_ACK;
        end else begin
            busState_r <= BUS_IDLE;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            readData_r <= 32'h00000000;
        end else if (rdTake) begin
            readData_r <= rdMux;
        end
    end

    assign readdata = readData_r;

    // classification enables
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            classifyEn_r <= `RST_CLASSIFY_EN;
        end else if (wrCls) begin
            classifyEn_r <= writedata[`CLS_VLAN_BIT:`CLS_DSCP_BIT];
        end
    end

    // frame control
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ceilEn_r <= frameCtrlReset[`FC_CEIL_BIT];
            dropUntag_r <= frameCtrlReset[`FC_DROP_UNTAG_BIT];
            dropTag_r <= frameCtrlReset[`FC_DROP_TAG_BIT];
            defPrio_r <= frameCtrlReset[`FC_DEF_PRIO_MSB:0];
        end else if (wrFc) begin
            ceilEn_r <= writedata[`FC_CEIL_BIT];
            dropUntag_r <= writedata[`FC_DROP_UNTAG_BIT];
            dropTag_r <= writedata[`FC_DROP_TAG_BIT];
            defPrio_r <= writedata[`FC_DEF_PRIO_MSB:0];
        end
    end

    // authentication mode
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            authMode_r <= `RST_AUTH_MODE;
        end else if (wrAc) begin
            authMode_r <= writedata[1:0];
        end
    end

    // default tag priority
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            defTagPrio_r <= `RST_DEF_TAG_PRIO;
        end else if (wrDef) begin
            defTagPrio_r <= writedata[2:0];
        end
    end

    // indirect pointer, port index
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            portIdx_r <= `RST_PORT_IDX;
        end else if (wrPtrPort) begin
            portIdx_r <= writedata[`PTR_PORT_MSB:`PTR_PORT_LSB];
        end
    end

    // indirect pointer, queue
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            queuePtr_r <= `RST_QUEUE_PTR;
        end else if (wrPtrQueue) begin
            queuePtr_r <= writedata[`PTR_QUEUE_MSB:0];
        end
    end

    assign portIndex = portIdx_r;
    assign queuePtr = queuePtr_r;

    // priority to queue table, byte lanes
    wire [31:0] mapWrMask = {{8{wrMapLane[3]}}, {8{wrMapLane[2]}},
        {8{wrMapLane[1]}}, {8{wrMapLane[0]}}} & 32'h33333333;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prioMap_r <= `RST_PRIO_MAP;
        end else begin
            prioMap_r <= (prioMap_r & ~mapWrMask)
                | (writedata & mapWrMask);
        end
    end

    // user priority ceiling
    wire overCeil = frmTagged & (frmUserPrio > defTagPrio_r);
    wire prio_t userPrioOut = (ceilEn_r & overCeil) ? defTagPrio_r
        : frmUserPrio;

    // priority classification, dscp over 802.1p over vlan
    wire useDscp = classifyEn_r[0] & dscpHit;
    wire useDot1p = classifyEn_r[1] & frmTagged;
    wire useVlan = classifyEn_r[2] & vlanHit;
    wire prio_t prioSel =
        useDscp ? dscpPrio :
        useDot1p ? userPrioOut :
        useVlan ? vlanPrio :
        defPrio_r;

    queue_t queueSel;

    queue_map_lookup queue_map_lookup_i (
        .mapTable(prioMap_r),
        .prio(prioSel),
        .queue(queueSel)
    );

    // tag filtering
    wire untagDrop = dropUntag_r & ~frmTagged;
    wire taggedDrop = dropTag_r & frmTagged;
    wire tagDrop = untagDrop | taggedDrop;

    // authentication and acl outcome
    wire aclMiss = aclEnable & ~aclHit;
    wire aclAct = aclEnable & aclHit;
    wire authBlocked = (authMode_r == `AUTH_BLOCK)
        & (aclEnable ? aclMiss : 1'b1);
    wire trapMode = (authMode_r == `AUTH_TRAP);
    wire trapBlocked = trapMode & aclMiss;
    wire authDrop = authBlocked | trapBlocked;
    wire toHost = trapMode & ~aclMiss & ~aclAct;

    // decision register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            decValid_r <= 1'b0;
        end else begin
            decValid_r <= frmValid;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            decDrop_r <= 1'b0;
            decToHost_r <= 1'b0;
            decAclApply_r <= 1'b0;
        end else if (frmValid) begin
            decDrop_r <= tagDrop | authDrop;
            decToHost_r <= toHost;
            decAclApply_r <= aclAct;
        end
    end

    // decision priority and queue
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            decUserPrio_r <= 3'h0;
            decPrio_r <= 3'h0;
            decQueue_r <= 2'h0;
        end else if (frmValid) begin
            decUserPrio_r <= userPrioOut;
            decPrio_r <= prioSel;
            decQueue_r <= queueSel;
        end
    end

    assign decValid = decValid_r;
    assign decDrop = decDrop_r;
    assign decToHost = decToHost_r;
    assign decAclApply = decAclApply_r;
    assign decUserPrio = decUserPrio_r;
    assign decPrio = decPrio_r;
    assign decQueue = decQueue_r;

endmodule : port_ingress_classify_ctrl

//--- bench/port_ingress_classify_ctrl_asserts.sv
// Purpose: port checks of the ingress control block
// Assumes: read data stand in the cycle waitrequest is low
// Notes: bound into the design top
`timescale 1ns/1ps
`include "port_ingress_consts.svh"
module port_ingress_classify_ctrl_asserts (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // bus
    input wire logic [`ADDR_W-1:0] address,
    input wire logic read,
    input wire logic [`DATA_W-1:0] readdata,
    input wire logic waitrequest,
    // frame side
    input wire logic aclEnable,
    input wire logic frmValid,
    input wire logic aclHit,
    input wire logic decValid,
    input wire logic decToHost,
    input wire logic decAclApply,
    input wire port_ingress_pkg::prio_t portIndex,
    input wire port_ingress_pkg::queue_t queuePtr
);
    import port_ingress_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // read completing at one register
    sequence rdDone(logic [11:0] idx);
        read && !waitrequest && address[13:2] == idx;
    endsequence
    AST_ACL_FLAG: assert property (
        rdDone(`IDX_AUTH_CTRL) |-> readdata[2] == $past(aclEnable))
        else $error("acl flag readback wrong");
    AST_AUTH_RSVD: assert property (
        rdDone(`IDX_AUTH_CTRL) |-> readdata[31:3] == 29'h0)
        else $error("auth reserved bits not zero");
    AST_FC_RSVD: assert property (
        rdDone(`IDX_FRAME_CTRL) |-> readdata[31:8] == 24'h0
        && readdata[6:5] == 2'h0) else $error("frame ctrl reserved set");
    AST_PTR_PORT: assert property (
        rdDone(`IDX_QUEUE_PTR) |-> readdata[31:16] == {13'h0, portIndex})
        else $error("port index readback wrong");
    AST_PTR_QUEUE: assert property (
        rdDone(`IDX_QUEUE_PTR) |-> readdata[15:0] == {14'h0, queuePtr})
        else $error("queue pointer readback wrong");
    AST_MAP_RSVD: assert property (
        rdDone(`IDX_PRIO_MAP) |-> (readdata & 32'hcccccccc) == 32'h0)
        else $error("map reserved bits set");
    AST_ACL_APPLY: assert property (
        frmValid |=> decAclApply == ($past(aclEnable) && $past(aclHit)))
        else $error("acl apply wrong");
    AST_TRAP_ACL: assert property (
        frmValid && aclEnable |=> !decToHost)
        else $error("host trap with acl on");
    AST_DEC_PULSE: assert property (
        frmValid |=> decValid) else $error("decision missing");
    AST_DEC_IDLE: assert property (
        !frmValid |=> !decValid) else $error("decision without frame");
endmodule : port_ingress_classify_ctrl_asserts

bind port_ingress_classify_ctrl port_ingress_classify_ctrl_asserts
    port_ingress_classify_ctrl_asserts_i (.core_clk(core_clk),
    .arst_n(arst_n), .address(address), .read(read), .readdata(readdata),
    .waitrequest(waitrequest), .aclEnable(aclEnable), .frmValid(frmValid),
    .aclHit(aclHit), .decValid(decValid), .decToHost(decToHost),
    .decAclApply(decAclApply), .portIndex(portIndex), .queuePtr(queuePtr));

//--- bench/tb_port_ingress_classify_ctrl.sv
// Purpose: self-checking bench of the ingress control block
// Assumes: one request on the bus at a time
// Notes: expected results queued by drivers, popped by a monitor
`timescale 1ns/1ps
`include "port_ingress_consts.svh"
module tb_port_ingress_classify_ctrl;
    import port_ingress_pkg::*;
    logic core_clk = 0, arst_n = 0, read = 0, write = 0, waitrequest;
    logic [`ADDR_W-1:0] address = '0;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] writedata = '0, readdata, regCls, regFc, regAuth, regMap;
    logic [31:0] regDef;
    logic aclEnable = 0, frmValid = 0, frmTagged = 0, dscpHit = 0;
    logic vlanHit = 0, aclHit = 0, decValid, decDrop, decToHost, decAclApply;
    prio_t frmUserPrio = 0, dscpPrio = 0, vlanPrio = 0;
    prio_t decUserPrio, decPrio, portIndex;
    queue_t decQueue, queuePtr;
    int mismatches = 0, n_checks = 0;
    logic [31:0] rdQ[$];
    logic [10:0] decQ[$];
    port_ingress_classify_ctrl port_ingress_classify_ctrl_i (
        .core_clk(core_clk), .arst_n(arst_n), .address(address),
        .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .aclEnable(aclEnable),
        .frmValid(frmValid), .frmTagged(frmTagged),
        .frmUserPrio(frmUserPrio), .dscpHit(dscpHit), .dscpPrio(dscpPrio),
        .vlanHit(vlanHit), .vlanPrio(vlanPrio), .aclHit(aclHit),
        .decValid(decValid), .decDrop(decDrop), .decToHost(decToHost),
        .decAclApply(decAclApply), .decUserPrio(decUserPrio),
        .decPrio(decPrio), .decQueue(decQueue), .portIndex(portIndex),
        .queuePtr(queuePtr));
    always #4 core_clk = ~core_clk;
    task cmp32(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp32
    task cmp11(input logic [10:0] got, input logic [10:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp11
    task bus(input logic wr, input logic [11:0] idx, input logic [3:0] be,
             input logic [31:0] d);
        @(posedge core_clk);
        read <= ~wr;
        write <= wr;
        address <= {idx, 2'b00};
        byteenable <= be;
        writedata <= d;
        @(posedge core_clk);
        while (waitrequest !== 1'b0) @(posedge core_clk);
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task rd(input logic [11:0] idx, input logic [31:0] exp);
        rdQ.push_back(exp);
        bus(1'b0, idx, 4'hf, 32'h0);
    endtask : rd
    task cfg(input logic [1:0] mode);
        regCls = $urandom;
        regFc = $urandom;
        if (mode == 2'h3) regFc[`FC_DROP_UNTAG_BIT] = 1'b0;
        regAuth = {30'($urandom), mode};
        regMap = $urandom;
        regDef = $urandom;
        bus(1'b1, `IDX_CLASSIFY_EN, 4'hf, regCls);
        bus(1'b1, `IDX_FRAME_CTRL, 4'hf, regFc);
        bus(1'b1, `IDX_AUTH_CTRL, 4'hf, regAuth);
        bus(1'b1, `IDX_PRIO_MAP, 4'hf, regMap);
        bus(1'b1, `IDX_DEF_TAG_PRIO, 4'hf, regDef);
        regAuth &= 32'h3;
        rd(`IDX_AUTH_CTRL, regAuth | {aclEnable, 2'b00});
        rd(`IDX_CLASSIFY_EN, regCls & 32'he);
    endtask : cfg
    task frame();
        logic t, dh, vh, ah;
        prio_t up, dp, vp, p, u;
        logic [1:0] m;
        {t, dh, vh, ah, up, dp, vp} = 13'($urandom);
        u = (regFc[7] && t && up > regDef[2:0]) ? regDef[2:0] : up;
        p = (regCls[1] && dh) ? dp : (regCls[2] && t) ? u :
            (regCls[3] && vh) ? vp : regFc[2:0];
        m = regAuth[1:0];
        decQ.push_back({(regFc[4] & ~t) | (regFc[3] & t) |
            (m == 2'h1 & ~(aclEnable & ah)) | (m == 2'h2 & aclEnable & ~ah),
            m == 2'h2 & ~aclEnable, aclEnable & ah,
            u, p, regMap[4*p +: 2]});
        @(posedge core_clk);
        frmValid <= 1'b1;
        {frmTagged, dscpHit, vlanHit, aclHit} <= {t, dh, vh, ah};
        {frmUserPrio, dscpPrio, vlanPrio} <= {up, dp, vp};
    endtask : frame
    always @(negedge core_clk) begin
        if (read === 1'b1 && waitrequest === 1'b0)
            cmp32(readdata, rdQ.pop_front());
        if (decValid === 1'b1)
            cmp11({decDrop, decToHost, decAclApply, decUserPrio, decPrio,
                   decQueue}, decQ.pop_front());
    end
    task print_verdict();
        mismatches += rdQ.size() + decQ.size();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict
    initial begin
        #500000;
        mismatches++;
        print_verdict();
    end
    initial begin
        void'($urandom(59));
        repeat (8) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(`IDX_FRAME_CTRL, 32'h0);
        rd(`IDX_AUTH_CTRL, 32'h0);
        rd(`IDX_QUEUE_PTR, 32'h0);
        rd(`IDX_PRIO_MAP, 32'h33221100);
        $display("test reset values done");
        bus(1'b1, 12'h900, 4'hf, '1);
        rd(12'h900, 32'h0);
        bus(1'b1, `IDX_FRAME_CTRL, 4'hf, '1);
        rd(`IDX_FRAME_CTRL, 32'h9f);
        bus(1'b1, `IDX_FRAME_CTRL, 4'he, '0);
        rd(`IDX_FRAME_CTRL, 32'h9f);
        aclEnable <= 1'b1;
        bus(1'b1, `IDX_QUEUE_PTR, 4'h4, '1);
        rd(`IDX_QUEUE_PTR, 32'h00070000);
        bus(1'b1, `IDX_QUEUE_PTR, 4'h1, '1);
        rd(`IDX_QUEUE_PTR, 32'h00070003);
        bus(1'b1, `IDX_PRIO_MAP, 4'hf, '1);
        rd(`IDX_PRIO_MAP, 32'h33333333);
        bus(1'b1, `IDX_PRIO_MAP, 4'h2, '0);
        rd(`IDX_PRIO_MAP, 32'h33330033);
        $display("test reserved bits done");
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(`IDX_FRAME_CTRL, 32'h0);
        rd(`IDX_QUEUE_PTR, 32'h0);
        rd(`IDX_PRIO_MAP, 32'h33221100);
        $display("test mid-run reset done");
        for (int k = 0; k < 12; k++) begin
            aclEnable <= 1'($urandom);
            cfg(2'(k));
            repeat (16) frame();
            @(posedge core_clk);
            frmValid <= 1'b0;
        end
        repeat (3) @(posedge core_clk);
        $display("test random frames done");
        print_verdict();
    end
endmodule : tb_port_ingress_classify_ctrl
